// *** design/lpwm_mgr.sv ***
// low-power mode sequencer, wakeup manager and interconnect gating
`timescale 1ns/10ps
// Function
// - in stop, a wake peripheral may get the fast osc, clocking only it
// - in stop, fast oscillator turns off automatically when no requester remains
// - serial receivers wake the chip on a start bit in stop
// - lowpower serial matches on crystal; standard serial needs fast osc
// - two-wire target address match wakes the chip from stop
// - two-wire reception in stop requests the fast oscillator
// - wakeup latencies 0.36, 3, 32, 3.5, 50 us per state
// - comparator to general timers not in stop; to lowpower timer except standby
// - timer to timer triggering blocked in stop
// - clock events hit lowpower timer except standby; auto wakeup not in stop
// - clock source measurement path blocked in stop
// - usb clock recovery trims only in run and sleep
// - usb frame marker timer input only in run and sleep
// - pins trigger general timers except in stop, standby and wake; lowpower timer except standby
// - deep sleep request enters stop or standby quickly
// - stop gates core clocks, fast osc runs only for requesters; any wake line wakes
module lpwm_mgr
  import lpwm_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sleep_req,
  input wire logic deep_req,
  input wire logic deep_standby,
  input wire logic lp_reg,
  input wire logic lprun_req,
  input wire logic wake_line,
  input wire logic standby_wake,
  input wire logic ser_start,
  input wire logic ser_match,
  input wire logic ser_need_osc,
  input wire logic lps_start,
  input wire logic lps_match,
  input wire logic tw_addr_match,
  input wire logic tw_rx_busy,
  input wire logic lpt_need_osc,
  input wire logic cmp_evt,
  input wire logic tmr_trig_in,
  input wire logic rtc_evt,
  input wire logic autowake_evt,
  input wire logic clk_meas_in,
  input wire logic usb_sof,
  input wire logic gpio_evt,
  output logic [2:0] power_state,
  output logic core_clk_en,
  output logic cpu_ready,
  output logic osc_on,
  output logic [LPWM_NREQ-1:0] osc_grant,
  output logic wake_irq,
  output logic cmp_to_gtimer,
  output logic cmp_to_lptimer,
  output logic tmr_to_tmr,
  output logic rtc_to_lptimer,
  output logic autowake_to_gtimer_b,
  output logic clk_to_timer,
  output logic sof_to_recovery,
  output logic sof_to_gtimer_c,
  output logic gpio_to_gtimer,
  output logic gpio_to_lptimer
);

  //////////////////////////////////////////////////////////////////////////
  lpwm_state_t state_q;
  lpwm_state_t state_d;
  logic [LPWM_CNT_W-1:0] cnt_q;
  logic wake_src;
  logic in_stop;
  logic run_like;
  logic gen_ok;

  function automatic logic [LPWM_CNT_W-1:0] wake_cycles(lpwm_state_t s);
    case (s)
      LPWM_SLEEP: wake_cycles = LPWM_CNT_W'(LPWM_WAKE_SLEEP_CYC);
      LPWM_LPRUN: wake_cycles = LPWM_CNT_W'(LPWM_WAKE_LPRUN_CYC);
      LPWM_LPSLEEP: wake_cycles = LPWM_CNT_W'(LPWM_WAKE_LPSLEEP_CYC);
      LPWM_STOP: wake_cycles = LPWM_CNT_W'(LPWM_WAKE_STOP_CYC);
      LPWM_STANDBY: wake_cycles = LPWM_CNT_W'(LPWM_WAKE_STANDBY_CYC);
      default: wake_cycles = LPWM_CNT_W'(1);
    endcase
  endfunction

  assign in_stop = (state_q == LPWM_STOP);
  assign run_like = (state_q == LPWM_RUN) || (state_q == LPWM_SLEEP);
  assign gen_ok = !in_stop && (state_q != LPWM_STANDBY) &&
    (state_q != LPWM_WAKE);

  // standby keeps only its own wake pins; everything else needs core power
  always_comb begin
    wake_src = 1'b0;
    case (state_q)
      LPWM_STOP: wake_src = wake_line | ser_start | lps_start | ser_match |
        lps_match | tw_addr_match;
      LPWM_STANDBY: wake_src = standby_wake;
      LPWM_SLEEP, LPWM_LPSLEEP: wake_src = wake_line | ser_start |
        lps_start | tw_addr_match;
      LPWM_LPRUN: wake_src = !lprun_req;
      default: wake_src = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    case (state_q)
      LPWM_RUN: begin
        if (deep_req) begin
          state_d = deep_standby ? LPWM_STANDBY : LPWM_STOP;
        end else if (sleep_req) begin
          state_d = lp_reg ? LPWM_LPSLEEP : LPWM_SLEEP;
        end else if (lprun_req) begin
          state_d = LPWM_LPRUN;
        end
      end
      LPWM_SLEEP, LPWM_LPSLEEP, LPWM_STOP, LPWM_STANDBY, LPWM_LPRUN: begin
        if (wake_src) begin
          state_d = LPWM_WAKE;
        end
      end
      LPWM_WAKE: begin
        if (cnt_q <= LPWM_CNT_W'(1)) begin
          state_d = LPWM_RUN;
        end
      end
      default: state_d = LPWM_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= LPWM_RUN;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // latency counter loaded from the state being left
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= LPWM_CNT_RST;
    end else if (ce) begin
      if (state_d == LPWM_WAKE && state_q != LPWM_WAKE) begin
        cnt_q <= wake_cycles(state_q);
      end else if (cnt_q != LPWM_CNT_RST) begin
        cnt_q <= cnt_q - LPWM_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_irq <= 1'b0;
    end else if (ce) begin
      wake_irq <= (state_q != LPWM_RUN) && (state_q != LPWM_LPRUN) &&
        (state_q != LPWM_WAKE) && wake_src;
    end
  end

  assign power_state = state_q;
  assign cpu_ready = (state_q == LPWM_RUN) || (state_q == LPWM_LPRUN);
  assign core_clk_en = !in_stop && (state_q != LPWM_STANDBY);

  //////////////////////////////////////////////////////////////////////////
  // requesters: standard serial, two-wire, lowpower serial, lowpower timer
  logic [LPWM_NREQ-1:0] osc_req;
  // lowpower serial runs from the crystal, so it never asks for the osc
  assign osc_req = {lpt_need_osc, 1'b0, tw_rx_busy,
    ser_need_osc};

  lpwm_osc_arb u_arb (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .stop_mode(in_stop),
    .run_need(run_like),
    .req(osc_req),
    .osc_on(osc_on),
    .grant(osc_grant)
  );

  //////////////////////////////////////////////////////////////////////////
  // interconnect gating, registered so triggers stay glitch free
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmp_to_gtimer <= 1'b0;
      tmr_to_tmr <= 1'b0;
      autowake_to_gtimer_b <= 1'b0;
      clk_to_timer <= 1'b0;
      gpio_to_gtimer <= 1'b0;
    end else if (ce) begin
      cmp_to_gtimer <= cmp_evt & gen_ok;
      tmr_to_tmr <= tmr_trig_in & gen_ok;
      autowake_to_gtimer_b <= autowake_evt & gen_ok;
      clk_to_timer <= clk_meas_in & gen_ok;
      gpio_to_gtimer <= gpio_evt & gen_ok;
    end
  end

  // lowpower timer paths stay live in stop; standby has no core power
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmp_to_lptimer <= 1'b0;
      rtc_to_lptimer <= 1'b0;
      gpio_to_lptimer <= 1'b0;
    end else if (ce) begin
      cmp_to_lptimer <= cmp_evt & (state_q != LPWM_STANDBY);
      rtc_to_lptimer <= rtc_evt & (state_q != LPWM_STANDBY);
      gpio_to_lptimer <= gpio_evt & (state_q != LPWM_STANDBY);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sof_to_recovery <= 1'b0;
      sof_to_gtimer_c <= 1'b0;
    end else if (ce) begin
      sof_to_recovery <= usb_sof & run_like;
      sof_to_gtimer_c <= usb_sof & run_like;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence s_stop_wake;
    ce && in_stop && wake_line;
  endsequence

  a_deep_entry: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && state_q == LPWM_RUN && deep_req && !deep_standby
    |=> state_q == LPWM_STOP)
    else $error("deep sleep did not enter stop");

  a_stop_wake: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_stop_wake |=> state_q == LPWM_WAKE &&
    cnt_q == LPWM_CNT_W'(LPWM_WAKE_STOP_CYC))
    else $error("stop wake latency load wrong");

  a_sleep_wake: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && state_q == LPWM_SLEEP && wake_line
    |=> cnt_q == LPWM_CNT_W'(LPWM_WAKE_SLEEP_CYC))
    else $error("sleep wake latency load wrong");

  a_stop_clk_off: assert property (
    @(posedge mclk) disable iff (!nrst)
    in_stop |-> !core_clk_en)
    else $error("core clock running in stop");

  a_ser_wake: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && in_stop && ser_start |=> wake_irq)
    else $error("start bit did not wake");

  a_tw_wake: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && in_stop && tw_addr_match |=> wake_irq)
    else $error("address match did not wake");

  a_tw_osc: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && in_stop && tw_rx_busy |=> osc_on)
    else $error("two-wire reception without oscillator");

  a_stop_gate: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && in_stop |=> !cmp_to_gtimer && !tmr_to_tmr && !gpio_to_gtimer &&
    !clk_to_timer && !autowake_to_gtimer_b)
    else $error("general timer path live in stop");

  a_lpt_live: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && in_stop && rtc_evt && gpio_evt |=> rtc_to_lptimer &&
    gpio_to_lptimer)
    else $error("lowpower timer path dead in stop");

  a_sof_gate: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && !run_like |=> !sof_to_recovery && !sof_to_gtimer_c)
    else $error("frame marker passed outside run");

  a_clk_meas: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && state_q == LPWM_LPRUN && clk_meas_in |=> clk_to_timer)
    else $error("measurement path dead in lowpower run");

endmodule

// *** design/lpwm_pkg.sv ***
// package: power states, wakeup latencies and sequencer constants
package lpwm_pkg;

  typedef enum logic [2:0] {
    LPWM_RUN = 3'h0,
    LPWM_SLEEP = 3'h1,
    LPWM_LPRUN = 3'h3,
    LPWM_LPSLEEP = 3'h2,
    LPWM_STOP = 3'h6,
    LPWM_STANDBY = 3'h7,
    LPWM_WAKE = 3'h5
  } lpwm_state_t;

  localparam int LPWM_CLK_MHZ = 200;
  // wakeup latencies in nanoseconds
  localparam int LPWM_WAKE_SLEEP_NS = 360;
  localparam int LPWM_WAKE_LPRUN_NS = 3000;
  localparam int LPWM_WAKE_LPSLEEP_NS = 32000;
  localparam int LPWM_WAKE_STOP_NS = 3500;
  localparam int LPWM_WAKE_STANDBY_NS = 50000;
  localparam int LPWM_CLK_PERIOD_NS = 1000 / LPWM_CLK_MHZ;

  localparam int LPWM_WAKE_SLEEP_CYC = LPWM_WAKE_SLEEP_NS / LPWM_CLK_PERIOD_NS;
  localparam int LPWM_WAKE_LPRUN_CYC = LPWM_WAKE_LPRUN_NS / LPWM_CLK_PERIOD_NS;
  localparam int LPWM_WAKE_LPSLEEP_CYC =
    LPWM_WAKE_LPSLEEP_NS / LPWM_CLK_PERIOD_NS;
  localparam int LPWM_WAKE_STOP_CYC = LPWM_WAKE_STOP_NS / LPWM_CLK_PERIOD_NS;
  localparam int LPWM_WAKE_STANDBY_CYC =
    LPWM_WAKE_STANDBY_NS / LPWM_CLK_PERIOD_NS;

  localparam int LPWM_CNT_W = 16;
  localparam int LPWM_NREQ = 4;
  localparam logic [LPWM_CNT_W-1:0] LPWM_CNT_RST = 16'h0000;

endpackage

// *** design/lpwm_osc_arb.sv ***
// fast oscillator on-demand arbiter with per-requester clock gates
`timescale 1ns/10ps
module lpwm_osc_arb
  import lpwm_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic stop_mode,
  input wire logic run_need,
  input wire logic [LPWM_NREQ-1:0] req,
  output logic osc_on,
  output logic [LPWM_NREQ-1:0] grant
);

  logic [LPWM_NREQ-1:0] grant_q;
  logic osc_q;

  // oscillator follows demand; drops with no software help
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_q <= 1'b0;
    end else if (ce) begin
      osc_q <= run_need | (stop_mode & (|req));
    end
  end

  // in stop only requesters see the clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      grant_q <= '0;
    end else if (ce) begin
      grant_q <= stop_mode ? req : {LPWM_NREQ{run_need}};
    end
  end

  assign osc_on = osc_q;
  assign grant = grant_q;

  a_osc_off_idle: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && stop_mode && !run_need && req == '0 |=> !osc_on)
    else $error("oscillator left on without requester");

  a_osc_on_req: assert property (
    @(posedge mclk) disable iff (!nrst)
    ce && stop_mode && (|req) |=> osc_on && grant == $past(req))
    else $error("requester not served in stop");

endmodule

// *** test/lpwm_periph_model.sv ***
// peripheral-side model that asks for the fast oscillator for a set time
`timescale 1ns/10ps
module lpwm_periph_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [3:0] len,
  output logic ser_need_osc,
  output logic tw_rx_busy,
  output logic lpt_need_osc
);
  logic [3:0] cnt_q;
  logic [1:0] sel_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      sel_q <= 2'h0;
    end else if (go) begin
      cnt_q <= len;
      sel_q <= sel;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the need drops by itself when the transfer ends, no one clears it
  assign ser_need_osc = (cnt_q != 4'h0) && (sel_q == 2'h0);
  assign tw_rx_busy = (cnt_q != 4'h0) && (sel_q == 2'h1);
  assign lpt_need_osc = (cnt_q != 4'h0) && (sel_q == 2'h2);
endmodule

// *** test/test_lpwm_mgr.sv ***
// testbench for the low-power mode and wakeup manager
`timescale 1ns/10ps
module test_lpwm_mgr;
  import lpwm_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [4:0] rq = 5'h00;
  logic [6:0] wk = 7'h00;
  logic [6:0] src = 7'h00;
  logic go = 1'b0;
  logic [1:0] sel = 2'h0;
  logic ser_need_osc, tw_rx_busy, lpt_need_osc;
  logic [2:0] power_state;
  logic core_clk_en, cpu_ready, osc_on, wake_irq;
  logic [LPWM_NREQ-1:0] osc_grant;
  logic [9:0] path;
  logic [2:0] st_e = 3'h0;
  logic chk_on = 1'b0;
  logic [19:0] q[$];
  logic [19:0] mon_e;
  int fails = 0;
  int checked = 0;
  int seed = 47173;
  int lat;
  logic seen;

  always #2.5 mclk = ~mclk;

  lpwm_periph_model peer_u (.mclk(mclk), .nrst(nrst), .go(go), .sel(sel),
    .len(4'h5), .ser_need_osc(ser_need_osc), .tw_rx_busy(tw_rx_busy),
    .lpt_need_osc(lpt_need_osc));

  lpwm_mgr dut_u (.mclk(mclk), .nrst(nrst), .ce(ce),
    .sleep_req(rq[4]), .deep_req(rq[3]), .deep_standby(rq[2]),
    .lp_reg(rq[1]), .lprun_req(rq[0]), .wake_line(wk[0]),
    .standby_wake(wk[6]), .ser_start(wk[1]), .ser_match(wk[3]),
    .ser_need_osc(ser_need_osc), .lps_start(wk[2]), .lps_match(wk[4]),
    .tw_addr_match(wk[5]), .tw_rx_busy(tw_rx_busy),
    .lpt_need_osc(lpt_need_osc), .cmp_evt(src[0]), .tmr_trig_in(src[1]),
    .rtc_evt(src[2]), .autowake_evt(src[3]), .clk_meas_in(src[4]),
    .usb_sof(src[5]), .gpio_evt(src[6]), .power_state(power_state),
    .core_clk_en(core_clk_en), .cpu_ready(cpu_ready), .osc_on(osc_on),
    .osc_grant(osc_grant), .wake_irq(wake_irq), .cmp_to_gtimer(path[0]),
    .cmp_to_lptimer(path[1]), .tmr_to_tmr(path[2]),
    .rtc_to_lptimer(path[3]), .autowake_to_gtimer_b(path[4]),
    .clk_to_timer(path[5]), .sof_to_recovery(path[6]),
    .sof_to_gtimer_c(path[7]), .gpio_to_gtimer(path[8]),
    .gpio_to_lptimer(path[9]));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] pred(logic [2:0] s, logic [6:0] x,
                                       logic [2:0] nd);
    logic a, n, r, off, cpu, st;
    logic [9:0] p;
    a = s inside {LPWM_RUN, LPWM_SLEEP, LPWM_LPRUN, LPWM_LPSLEEP};
    n = (s != LPWM_STANDBY);
    r = s inside {LPWM_RUN, LPWM_SLEEP};
    off = s inside {LPWM_STOP, LPWM_STANDBY};
    cpu = s inside {LPWM_RUN, LPWM_LPRUN};
    p[1:0] = {x[0] & n, x[0] & a};
    p[2] = x[1] & a;
    p[4:3] = {x[3] & a, x[2] & n};
    p[5] = x[4] & a;
    p[6] = x[5] & r;
    p[7] = x[5] & r;
    p[9:8] = {x[6] & n, x[6] & a};
    st = (s == LPWM_STOP);
    // outside stop the oscillator simply follows run or sleep
    return {s, ~off, cpu, p, st ? |nd : r,
            st ? {nd[2], 1'b0, nd[1:0]} : {4{r}}};
  endfunction

  task automatic chk(logic [19:0] o, logic [19:0] e);
    checked++;
    if (o !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, o, e);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // the note is taken from what the design samples at this very edge
  always @(posedge mclk) begin
    if (chk_on) begin
      q.push_back(pred(st_e, src, {lpt_need_osc, tw_rx_busy, ser_need_osc}));
    end
    src <= 7'($random(seed));
  end

  // outputs are settled half a cycle after the edge that launched them
  always @(negedge mclk) begin
    if (q.size() > 0) begin
      mon_e = q.pop_front();
      chk({power_state, core_clk_en, cpu_ready, path, osc_on, osc_grant},
          mon_e);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic visit(logic [2:0] s, logic [4:0] r, int w, int n,
                       logic [1:0] sl);
    @(posedge mclk);
    rq <= r;
    @(posedge mclk);
    st_e <= s;
    chk_on <= 1'b1;
    repeat (2) @(posedge mclk);
    go <= (s == LPWM_STOP);
    sel <= sl;
    @(posedge mclk);
    go <= 1'b0;
    repeat (10) @(posedge mclk);
    chk_on <= 1'b0;
    rq <= 5'h00;
    wk <= 7'(8'h01 << w);
    @(posedge mclk);
    wk <= 7'h00;
    seen = 1'b0;
    lat = 1;
    do begin
      @(negedge mclk);
      seen = seen | (wake_irq === 1'b1);
      lat++;
    end while (power_state !== LPWM_RUN && lat < 12000);
    if (lat >= 12000) begin
      fails++;
      conclude();
    end
    chk(20'(lat >= n - 2 && lat <= n + 3), 20'h1);
    if (s == LPWM_STOP) begin
      chk(20'(seen), 20'h1);
    end
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk_on <= 1'b1;
    repeat (10) @(posedge mclk);
    chk_on <= 1'b0;
    // a deep sleep request while frozen must leave the state alone
    ce <= 1'b0;
    rq <= 5'h08;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(20'(power_state), 20'(LPWM_RUN));
    @(posedge mclk);
    ce <= 1'b1;
    rq <= 5'h00;
    visit(LPWM_SLEEP, 5'h10, 0, 72, 2'h0);
    visit(LPWM_LPSLEEP, 5'h12, 0, 6400, 2'h0);
    visit(LPWM_LPRUN, 5'h01, 7, 600, 2'h0);
    for (int i = 0; i < 6; i++) begin
      visit(LPWM_STOP, 5'h08, i, 700, 2'(i % 3));
    end
    visit(LPWM_STANDBY, 5'h0c, 6, 10000, 2'h0);
    // reset in mid-run from stop must bring back the run state
    @(posedge mclk);
    rq <= 5'h08;
    @(posedge mclk);
    @(negedge mclk);
    chk(20'(power_state), 20'(LPWM_STOP));
    @(posedge mclk);
    nrst <= 1'b0;
    rq <= 5'h00;
    @(negedge mclk);
    chk({power_state, core_clk_en, cpu_ready, path, osc_on, osc_grant},
        20'h18000);
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule
